/* design/reset_ram_backup_defines.vh */
// Register map, field positions, reset values and codes for the sequencer
`ifndef RESET_RAM_BACKUP_DEFINES_VH
`define RESET_RAM_BACKUP_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define ADDR_STATUS 8'h00
`define ADDR_IRQCTL 8'h04
`define ADDR_TIMCTL 8'h08
`define ADDR_RETAIN 8'h0C
`define ADDR_FLAGS 8'h10

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define EI_LEVEL_BIT 2
`define EI_WAKE_BIT 3
`define FL_EXT 0
`define FL_T1 1
`define FL_CONV 2
`define FL_T2 3

// ----------------------------------------------------------------
// Reset and start values
// ----------------------------------------------------------------
`define PC_START 11'h000
`define SP_INIT 3'h7
`define NIB_RST 4'h0
`define WDT_EN_RST 1'b0
`define PD_COLD 1'b0
`define PD_WARM 1'b1

// ----------------------------------------------------------------
// Instruction codes seen on the decode strobe
// ----------------------------------------------------------------
`define OP_OTHER 3'h0
`define OP_ARM 3'h1
`define OP_POWER_OFF 3'h2
`define OP_WDT_RESTART 3'h3
`define OP_SKIP_PD 3'h4

`endif

/* design/reset_and_ram_backup_control.v */
// Reset and RAM retention sequencer with a Wishbone register slave
`timescale 1ns/1ps
`default_nettype none
`include "reset_ram_backup_defines.vh"

// Operation
// - Every reset and its release start execution at page 0 address 0.
// - Reset clears the global interrupt enable.
// - State without a reset value is undefined; software initialises it.
// - Retention entered only when power-off directly follows the arming op.
// - Power-off without the arming op just before is a no-operation.
// - Retention stops the oscillator; RAM and reset circuit keep working.
// - Retention ends only on an external wake-up input or a low reset pin.
// - Warm start resumes at page 0 address 0 with power-down flag 1.
// - Pin or watchdog reset resumes at address 0 with power-down flag 0.
// - Software tests the power-down flag with a skip-if-set op.
// - RAM, ports, timer two, wake, pull-up controls survive; clock control does not.
// - Warm start reinitialises CPU registers, timer one, irq, watchdog.
// - Warm start sets the stack pointer to level 7.
// - Timer two state and its flag are undefined after retention.
// - Anything not retained or reinitialised is undefined after retention.
// - At reset ports are high-impedance, latches 1, pull-ups off.
module reset_and_ram_backup_control #(
    parameter WDT_WIDTH = 16
) (
    // Clock and reset
    input wire sys_clk,
    input wire rst_b,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Pins
    input wire resetPin_b,
    input wire [3:0] keyPins,
    input wire intPin,
    // Instruction decode and peripheral events
    input wire instrStrobe,
    input wire [2:0] instrCode,
    input wire [3:0] flagEvents,
    // CPU and clock control
    output reg cpuInit,
    output reg [10:0] pcStart,
    output reg [2:0] stackInit,
    output reg clockRun,
    output reg skipNext,
    output reg powerDownFlag,
    output reg irqGlobalEnable,
    // Port control
    output reg portHighZ,
    output reg portLatchSet,
    output reg pullupOff
);

// ----------------------------------------------------------------
// States
// ----------------------------------------------------------------
localparam ST_RUN = 2'h0;
localparam ST_RETAIN = 2'h1;
localparam ST_WARM = 2'h2;
localparam ST_COLD = 2'h3;

reg [1:0] state;
reg [1:0] next_state;
reg armed;

// Reinitialised on every start
reg [3:0] irqControlFirst;
reg [3:0] irqControlSecond;
reg [3:0] timerOneControl;
reg [3:0] clockControlReg;
reg watchdogEnableFlag;
reg watchdogStatusFlag;
reg [WDT_WIDTH-1:0] watchdogCounter;
reg [2:0] eventFlags;

// Kept across retention, reset only cold
reg [3:0] wakeControlFirst;
reg [3:0] pullupControlFirst;
reg [3:0] extIrqControl;
reg [3:0] converterControl;
reg [3:0] timerTwoControl;
reg [3:0] timerAuxControl;

// Neither kept nor reinitialised by a start
reg timerTwoIrqFlag;

// ----------------------------------------------------------------
// Pin synchronisers
// ----------------------------------------------------------------
reg rpSync1;
reg rpSync2;
reg rpSync3;
reg resetPinLow;
reg [4:0] wakeSync1;
reg [4:0] wakeSync2;
reg [4:0] wakeSync3;
reg [4:0] wakeLevel;

// A level counts only once stages two and three agree
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        rpSync1 <= 1'b1;
        rpSync2 <= 1'b1;
        rpSync3 <= 1'b1;
        resetPinLow <= 1'b0;
        wakeSync1 <= 5'h1F;
        wakeSync2 <= 5'h1F;
        wakeSync3 <= 5'h1F;
        wakeLevel <= 5'h1F;
    end else begin
        rpSync1 <= resetPin_b;
        rpSync2 <= rpSync1;
        rpSync3 <= rpSync2;
        if (rpSync2 == rpSync3) begin
            resetPinLow <= ~rpSync3;
        end
        wakeSync1 <= {intPin, keyPins};
        wakeSync2 <= wakeSync1;
        wakeSync3 <= wakeSync2;
        wakeLevel <= (wakeSync2 & wakeSync3)
            | (wakeLevel & (wakeSync2 ^ wakeSync3));
    end
end

// ----------------------------------------------------------------
// Decode
// ----------------------------------------------------------------
wire isArm = instrStrobe & (instrCode == `OP_ARM);
wire isPowerOff = instrStrobe & (instrCode == `OP_POWER_OFF);
wire isWdtRestart = instrStrobe & (instrCode == `OP_WDT_RESTART);
wire isSkipPd = instrStrobe & (instrCode == `OP_SKIP_PD);
wire enterRetain = isPowerOff & armed & (state == ST_RUN);

// Keys wake on a low level; the int pin on its chosen level
wire [3:0] keyWake = ~wakeLevel[3:0] & wakeControlFirst;
wire intWake = extIrqControl[`EI_WAKE_BIT]
    & (wakeLevel[4] == extIrqControl[`EI_LEVEL_BIT]);
wire wakeUp = (|keyWake) | intWake;

wire wdtOverflow = (state == ST_RUN) & watchdogEnableFlag
    & (&watchdogCounter);
wire wdtReset = wdtOverflow & watchdogStatusFlag;
wire coldCause = resetPinLow | wdtReset;
wire restart = (state == ST_WARM) | (state == ST_COLD);

// ----------------------------------------------------------------
// Sequencer
// ----------------------------------------------------------------
always @* begin
    next_state = state;
    case (state)
        ST_RUN: begin
            if (coldCause) begin
                next_state = ST_COLD;
            end else if (enterRetain) begin
                next_state = ST_RETAIN;
            end
        end
        ST_RETAIN: begin
            // Clock is stopped here, so only pins can end it
            if (resetPinLow) begin
                next_state = ST_COLD;
            end else if (wakeUp) begin
                next_state = ST_WARM;
            end
        end
        ST_WARM: begin
            if (resetPinLow) begin
                next_state = ST_COLD;
            end else begin
                next_state = ST_RUN;
            end
        end
        default: begin
            if (!resetPinLow) begin
                next_state = ST_RUN;
            end
        end
    endcase
end

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        state <= ST_COLD;
        armed <= 1'b0;
        cpuInit <= 1'b1;
        pcStart <= `PC_START;
        stackInit <= `SP_INIT;
        clockRun <= 1'b1;
        skipNext <= 1'b0;
        powerDownFlag <= `PD_COLD;
        portHighZ <= 1'b1;
        portLatchSet <= 1'b1;
        pullupOff <= 1'b1;
    end else begin
        state <= next_state;
        // Any instruction in between disarms power-off
        if (restart) begin
            armed <= 1'b0;
        end else if (instrStrobe) begin
            armed <= isArm;
        end
        cpuInit <= (next_state != ST_RUN);
        pcStart <= `PC_START;
        stackInit <= `SP_INIT;
        clockRun <= (next_state != ST_RETAIN);
        skipNext <= isSkipPd & powerDownFlag;
        // Cleared as the cold state is entered, not one cycle later
        if (next_state == ST_COLD) begin
            powerDownFlag <= `PD_COLD;
        end else if (enterRetain) begin
            powerDownFlag <= `PD_WARM;
        end
        portHighZ <= (next_state == ST_COLD);
        portLatchSet <= (next_state == ST_COLD);
        pullupOff <= (next_state == ST_COLD);
    end
end

// ----------------------------------------------------------------
// Wishbone slave
// ----------------------------------------------------------------
wire wbReq = wb_cyc_i & wb_stb_i;
wire wbWr = wbReq & wb_we_i & wb_ack_o;
wire [31:0] byteMask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

function [31:0] merge;
    input [31:0] old;
    input [31:0] data;
    input [31:0] mask;
    begin
        merge = (old & ~mask) | (data & mask);
    end
endfunction

wire [31:0] irqWord = merge({20'h0, irqControlSecond,
    irqControlFirst, 3'h0, irqGlobalEnable}, wb_dat_i, byteMask);
wire [31:0] timWord = merge({23'h0, watchdogEnableFlag,
    clockControlReg, timerOneControl}, wb_dat_i, byteMask);
wire [31:0] retWord = merge({8'h0, timerAuxControl, timerTwoControl,
    converterControl, extIrqControl, pullupControlFirst,
    wakeControlFirst}, wb_dat_i, byteMask);
wire [3:0] flagClear = (wbWr && wb_adr_i == `ADDR_FLAGS)
    ? (wb_dat_i[3:0] & byteMask[3:0]) : 4'h0;

reg [31:0] readMux;
always @* begin
    if (wb_adr_i == `ADDR_STATUS) begin
        readMux = {26'h0, watchdogStatusFlag, armed, state,
            1'b0, powerDownFlag};
    end else if (wb_adr_i == `ADDR_IRQCTL) begin
        readMux = {20'h0, irqControlSecond, irqControlFirst,
            3'h0, irqGlobalEnable};
    end else if (wb_adr_i == `ADDR_TIMCTL) begin
        readMux = {23'h0, watchdogEnableFlag, clockControlReg,
            timerOneControl};
    end else if (wb_adr_i == `ADDR_RETAIN) begin
        readMux = {8'h0, timerAuxControl, timerTwoControl,
            converterControl, extIrqControl, pullupControlFirst,
            wakeControlFirst};
    end else if (wb_adr_i == `ADDR_FLAGS) begin
        readMux = {28'h0, timerTwoIrqFlag, eventFlags};
    end else begin
        readMux = 32'h0000_0000;
    end
end

always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= wbReq & ~wb_ack_o;
        if (wbReq & ~wb_ack_o) begin
            wb_dat_o <= readMux;
        end
    end
end

// ----------------------------------------------------------------
// Registers cleared on every start
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        irqGlobalEnable <= 1'b0;
        irqControlFirst <= `NIB_RST;
        irqControlSecond <= `NIB_RST;
        timerOneControl <= `NIB_RST;
        clockControlReg <= `NIB_RST;
        watchdogEnableFlag <= `WDT_EN_RST;
        eventFlags <= 3'h0;
    end else if (restart) begin
        irqGlobalEnable <= 1'b0;
        irqControlFirst <= `NIB_RST;
        irqControlSecond <= `NIB_RST;
        timerOneControl <= `NIB_RST;
        clockControlReg <= `NIB_RST;
        watchdogEnableFlag <= `WDT_EN_RST;
        eventFlags <= 3'h0;
    end else begin
        if (wbWr && wb_adr_i == `ADDR_IRQCTL) begin
            irqGlobalEnable <= irqWord[0];
            irqControlFirst <= irqWord[7:4];
            irqControlSecond <= irqWord[11:8];
        end
        if (wbWr && wb_adr_i == `ADDR_TIMCTL) begin
            timerOneControl <= timWord[3:0];
            clockControlReg <= timWord[7:4];
            watchdogEnableFlag <= timWord[8];
        end
        // A new event beats a clear in the same cycle
        eventFlags <= (eventFlags & ~flagClear[2:0])
            | flagEvents[2:0];
    end
end

// ----------------------------------------------------------------
// Watchdog
// ----------------------------------------------------------------
// First overflow marks, second overflow resets cold
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        watchdogCounter <= {WDT_WIDTH{1'b0}};
        watchdogStatusFlag <= 1'b0;
    end else if (restart) begin
        watchdogCounter <= {WDT_WIDTH{1'b0}};
        watchdogStatusFlag <= 1'b0;
    end else begin
        if (isWdtRestart) begin
            watchdogCounter <= {WDT_WIDTH{1'b0}};
        end else if (state == ST_RUN && watchdogEnableFlag) begin
            watchdogCounter <= watchdogCounter + 1'b1;
        end
        if (wdtOverflow) begin
            watchdogStatusFlag <= 1'b1;
        end
    end
end

// ----------------------------------------------------------------
// Registers kept across retention
// ----------------------------------------------------------------
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        wakeControlFirst <= `NIB_RST;
        pullupControlFirst <= `NIB_RST;
        extIrqControl <= `NIB_RST;
        converterControl <= `NIB_RST;
        timerTwoControl <= `NIB_RST;
        timerAuxControl <= `NIB_RST;
    end else if (state == ST_COLD) begin
        wakeControlFirst <= `NIB_RST;
        pullupControlFirst <= `NIB_RST;
        extIrqControl <= `NIB_RST;
        converterControl <= `NIB_RST;
        timerTwoControl <= `NIB_RST;
        timerAuxControl <= `NIB_RST;
    end else if (wbWr && wb_adr_i == `ADDR_RETAIN) begin
        wakeControlFirst <= retWord[3:0];
        pullupControlFirst <= retWord[7:4];
        extIrqControl <= retWord[11:8];
        converterControl <= retWord[15:12];
        timerTwoControl <= retWord[19:16];
        timerAuxControl <= retWord[23:20];
    end
end

// Starts leave it alone; software can only clear it through the flags register
always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
        timerTwoIrqFlag <= 1'b0;
    end else begin
        timerTwoIrqFlag <= (timerTwoIrqFlag & ~flagClear[`FL_T2])
            | flagEvents[`FL_T2];
    end
end

endmodule // reset_and_ram_backup_control
`default_nettype wire

/* bench/reset_ram_backup_chk.sv */
// Port assertions and bind for the retention sequencer
`timescale 1ns/1ps
`default_nettype none
`include "reset_ram_backup_defines.vh"
module reset_ram_backup_chk #(
    parameter WDT_WIDTH = 16
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and decode
    input wire logic resetPin_b,
    input wire logic [3:0] keyPins,
    input wire logic intPin,
    input wire logic instrStrobe,
    input wire logic [2:0] instrCode,
    input wire logic [3:0] flagEvents,
    // Sequencer outputs
    input wire logic cpuInit,
    input wire logic [10:0] pcStart,
    input wire logic [2:0] stackInit,
    input wire logic clockRun,
    input wire logic skipNext,
    input wire logic powerDownFlag,
    input wire logic irqGlobalEnable,
    input wire logic portHighZ,
    input wire logic portLatchSet,
    input wire logic pullupOff
);
    // ----------
    // Helpers
    // ----------
    // Cleared outside run so a restart never leaves a stale arm behind
    logic lastArm;
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b)
            lastArm <= 1'b0;
        else if (cpuInit)
            lastArm <= 1'b0;
        else if (instrStrobe)
            lastArm <= (instrCode == `OP_ARM);
    end
    wire logic offOp = instrStrobe && instrCode == `OP_POWER_OFF;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // ----------
    // Properties
    // ----------
    property p_restart;
        $fell(cpuInit) |-> pcStart == `PC_START && stackInit == `SP_INIT
            && !irqGlobalEnable;
    endproperty
    a_restart: assert property (p_restart)
        else $error("restart values wrong");
    property p_enter;
        offOp && lastArm && !cpuInit |=> !clockRun && powerDownFlag;
    endproperty
    a_enter: assert property (p_enter)
        else $error("armed power-off did not retain");
    property p_alone;
        offOp && !lastArm && !cpuInit |=> clockRun && $stable(powerDownFlag);
    endproperty
    a_alone: assert property (p_alone)
        else $error("unarmed power-off acted");
    property p_retain;
        !clockRun |-> cpuInit && powerDownFlag;
    endproperty
    a_retain: assert property (p_retain)
        else $error("oscillator stopped outside retention");
    // Holds while the int wake is left disabled and the reset pin stays high
    property p_wake_only;
        (!clockRun && keyPins == 4'hF) [*5] |=> !clockRun;
    endproperty
    a_wake_only: assert property (p_wake_only)
        else $error("left retention without wake");
    property p_warm;
        $rose(clockRun) |-> powerDownFlag && cpuInit
            ##[1:3] !cpuInit && powerDownFlag;
    endproperty
    a_warm: assert property (p_warm)
        else $error("warm start wrong");
    property p_cold;
        !resetPin_b [*6] |-> portHighZ && portLatchSet && pullupOff
            && cpuInit && !powerDownFlag;
    endproperty
    a_cold: assert property (p_cold)
        else $error("pin reset state wrong");
    property p_skip;
        instrStrobe && instrCode == `OP_SKIP_PD && !cpuInit
            |=> skipNext == $past(powerDownFlag);
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip does not follow flag");
    property p_ack;
        $rose(wb_stb_i) && wb_cyc_i |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack not one cycle");
    c_enter: cover property ($fell(clockRun));
    c_wake: cover property ($rose(clockRun));
    c_skip: cover property (skipNext);
endmodule // reset_ram_backup_chk

bind reset_and_ram_backup_control reset_ram_backup_chk #(
    .WDT_WIDTH(WDT_WIDTH)
) u_chk (
    .sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .resetPin_b, .keyPins,
    .intPin, .instrStrobe, .instrCode, .flagEvents, .cpuInit, .pcStart,
    .stackInit, .clockRun, .skipNext, .powerDownFlag, .irqGlobalEnable,
    .portHighZ, .portLatchSet, .pullupOff
);
`default_nettype wire

/* bench/wake_source_model.sv */
// Behavioural reset pin and wake key source facing the sequencer
`timescale 1ns/1ps
`default_nettype none
module wake_source_model (
    // Clock
    input wire logic sys_clk,
    // Pins toward the sequencer
    output logic resetPin_b,
    output logic [3:0] keyPins,
    output logic intPin
);
    // Pulled-up pins idle high; int pin parked low, its wake unused
    initial begin
        resetPin_b = 1'h1;
        keyPins = 4'hF;
        intPin = 1'h0;
    end
    task automatic setReset(input logic level);
        @(posedge sys_clk);
        resetPin_b <= level;
    endtask
    task automatic pressKey(input int k);
        @(posedge sys_clk);
        keyPins[k] <= 1'h0;
    endtask
    task automatic releaseKeys;
        @(posedge sys_clk);
        keyPins <= 4'hF;
    endtask
endmodule // wake_source_model
`default_nettype wire

/* bench/testbench.sv */
// Directed bench: bus and op sequences around retention and restart
`timescale 1ns/1ps
`default_nettype none
`include "reset_ram_backup_defines.vh"
module testbench;
    logic sys_clk = 1'h0;
    logic rst_b = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [3:0] flagEvents = 4'h0;
    logic instrStrobe = 1'h0;
    logic [2:0] instrCode = 3'h0;
    logic [31:0] rdData;
    int n_mismatch = 0;
    int checked = 0;
    wire logic [31:0] wb_dat_o;
    wire logic wb_ack_o, resetPin_b, intPin, cpuInit, clockRun, skipNext;
    wire logic powerDownFlag, irqGlobalEnable, portHighZ, portLatchSet;
    wire logic pullupOff;
    wire logic [3:0] keyPins;
    wire logic [10:0] pcStart;
    wire logic [2:0] stackInit;
    initial begin
        forever #25 sys_clk = ~sys_clk;
    end
    reset_and_ram_backup_control #(.WDT_WIDTH(4)) u_dut (
        .sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .resetPin_b,
        .keyPins, .intPin, .instrStrobe, .instrCode, .flagEvents,
        .cpuInit, .pcStart, .stackInit, .clockRun, .skipNext,
        .powerDownFlag, .irqGlobalEnable, .portHighZ, .portLatchSet,
        .pullupOff
    );
    wake_source_model u_src (.sys_clk, .resetPin_b, .keyPins, .intPin);
    // ----------
    // Tasks
    // ----------
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wbXfer(input logic w, input logic [7:0] a,
                          input logic [31:0] d);
        int i;
        @(posedge sys_clk);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        i = 0;
        // Ack looked at mid-cycle, where it has settled
        do begin
            @(negedge sys_clk);
            i++;
        end while (wb_ack_o !== 1'h1 && i < 20);
        if (wb_ack_o !== 1'h1)
            n_mismatch++;
        @(posedge sys_clk);
        rdData = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
    endtask
    task automatic op(input logic [2:0] c);
        @(posedge sys_clk);
        instrStrobe <= 1'h1;
        instrCode <= c;
        @(posedge sys_clk);
        instrStrobe <= 1'h0;
    endtask
    task automatic waitRun;
        int i;
        for (i = 0; i < 40 && cpuInit !== 1'h0; i++)
            @(posedge sys_clk);
    endtask
    task automatic summarize;
        $display("checked %0d n_mismatch %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ----------
    // Tests
    // ----------
    initial begin
        int i;
        repeat (2) @(posedge sys_clk);
        chk("portHighZ", portHighZ, 1);
        chk("portLatchSet", portLatchSet, 1);
        chk("pullupOff", pullupOff, 1);
        chk("powerDownFlag", powerDownFlag, 0);
        rst_b <= 1'h1;
        wbXfer(1, `ADDR_IRQCTL, 32'h561);
        wbXfer(0, `ADDR_IRQCTL, 32'h0);
        chk("irqctl", rdData, 32'h561);
        chk("irqGlobalEnable", irqGlobalEnable, 1);
        chk("pcStart", pcStart, `PC_START);
        chk("portHighZ", portHighZ, 0);
        wbXfer(0, 8'h40, 32'h0);
        chk("unmapped", rdData, 32'h0);
        $display("test reset: done");
        op(`OP_POWER_OFF);
        op(`OP_ARM);
        op(`OP_OTHER);
        op(`OP_POWER_OFF);
        @(negedge sys_clk);
        chk("clockRun", clockRun, 1);
        op(`OP_SKIP_PD);
        @(negedge sys_clk);
        chk("skipNext", skipNext, 0);
        $display("test no entry: done");
        wbXfer(1, `ADDR_RETAIN, 32'h653251);
        wbXfer(1, `ADDR_TIMCTL, 32'hA3);
        op(`OP_WDT_RESTART);
        op(`OP_ARM);
        op(`OP_POWER_OFF);
        @(negedge sys_clk);
        chk("clockRun", clockRun, 0);
        chk("powerDownFlag", powerDownFlag, 1);
        repeat (20) @(posedge sys_clk);
        chk("clockRun", clockRun, 0);
        u_src.pressKey(0);
        for (i = 0; i < 20 && clockRun !== 1'h1; i++)
            @(posedge sys_clk);
        chk("clockRun", clockRun, 1);
        u_src.releaseKeys();
        waitRun();
        chk("powerDownFlag", powerDownFlag, 1);
        chk("stackInit", stackInit, `SP_INIT);
        chk("irqGlobalEnable", irqGlobalEnable, 0);
        wbXfer(0, `ADDR_TIMCTL, 32'h0);
        chk("timctl", rdData, 32'h0);
        wbXfer(0, `ADDR_RETAIN, 32'h0);
        chk("retain", rdData, 32'h653251);
        wbXfer(0, `ADDR_STATUS, 32'h0);
        chk("status", rdData, 32'h1);
        op(`OP_SKIP_PD);
        @(negedge sys_clk);
        chk("skipNext", skipNext, 1);
        @(posedge sys_clk);
        flagEvents <= 4'hF;
        @(posedge sys_clk);
        flagEvents <= 4'h0;
        wbXfer(0, `ADDR_FLAGS, 32'h0);
        chk("flags", rdData, 32'hF);
        wbXfer(1, `ADDR_FLAGS, 32'h7);
        wbXfer(0, `ADDR_FLAGS, 32'h0);
        chk("flags", rdData, 32'h8);
        $display("test warm start: done");
        u_src.setReset(1'h0);
        repeat (8) @(posedge sys_clk);
        chk("portHighZ", portHighZ, 1);
        chk("powerDownFlag", powerDownFlag, 0);
        u_src.setReset(1'h1);
        waitRun();
        chk("powerDownFlag", powerDownFlag, 0);
        wbXfer(0, `ADDR_RETAIN, 32'h0);
        chk("retain", rdData, 32'h0);
        wbXfer(0, `ADDR_FLAGS, 32'h0);
        chk("flags", rdData, 32'h8);
        $display("test cold start: done");
        wbXfer(1, `ADDR_RETAIN, 32'h5);
        wbXfer(1, `ADDR_TIMCTL, 32'h100);
        for (i = 0; i < 60 && cpuInit !== 1'h1; i++)
            @(posedge sys_clk);
        chk("wdt cpuInit", cpuInit, 1);
        waitRun();
        chk("wdt powerDownFlag", powerDownFlag, 0);
        wbXfer(0, `ADDR_RETAIN, 32'h0);
        chk("wdt retain", rdData, 32'h0);
        $display("test watchdog cold start: done");
        summarize();
    end
    // A hang counts against the run
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end
endmodule // testbench
`default_nettype wire
